// *** src/exdm_map.vh ***
`ifndef EXDM_MAP_VH
`define EXDM_MAP_VH
// register byte offsets
`define EXDM_OFF_CMD 8'h00
`define EXDM_OFF_ADDR 8'h04
`define EXDM_OFF_IMM 8'h08
`define EXDM_OFF_ACC 8'h0c
`define EXDM_OFF_FLAG 8'h10
`define EXDM_OFF_STAT 8'h14
// flag bit positions
`define EXDM_F_C 0
`define EXDM_F_AC 1
`define EXDM_F_Z 2
`define EXDM_F_OV 3
`define EXDM_F_SC 4
// reset values
`define EXDM_RST_BYTE 8'h00
`define EXDM_RST_FLAG 5'h00
// axi responses
`define EXDM_RESP_OKAY 2'b00
`define EXDM_RESP_SLVERR 2'b10
// decimal adjust figures
`define EXDM_BCD_MAX 4'h9
`define EXDM_BCD_ADJ 4'h6
// opcodes
`define EXDM_OP_XOR_IMM 6'h00
`define EXDM_OP_XOR_ACC 6'h01
`define EXDM_OP_XOR_MEM 6'h02
`define EXDM_OP_ADC_ACC 6'h03
`define EXDM_OP_ADC_MEM 6'h04
`define EXDM_OP_ADD_ACC 6'h05
`define EXDM_OP_ADD_MEM 6'h06
`define EXDM_OP_AND_ACC 6'h07
`define EXDM_OP_AND_MEM 6'h08
`define EXDM_OP_OR_ACC 6'h09
`define EXDM_OP_OR_MEM 6'h0a
`define EXDM_OP_CLR_MEM 6'h0b
`define EXDM_OP_CLR_BIT 6'h0c
`define EXDM_OP_INV_MEM 6'h0d
`define EXDM_OP_INV_ACC 6'h0e
`define EXDM_OP_DAA 6'h0f
`define EXDM_OP_DEC_MEM 6'h10
`define EXDM_OP_DEC_ACC 6'h11
`define EXDM_OP_INC_MEM 6'h12
`define EXDM_OP_INC_ACC 6'h13
`define EXDM_OP_MOV_ACC 6'h14
`define EXDM_OP_MOV_MEM 6'h15
`define EXDM_OP_RL_MEM 6'h16
`define EXDM_OP_RL_ACC 6'h17
`define EXDM_OP_RLC_MEM 6'h18
`define EXDM_OP_RLC_ACC 6'h19
`define EXDM_OP_RR_MEM 6'h1a
`define EXDM_OP_RR_ACC 6'h1b
`define EXDM_OP_RRC_MEM 6'h1c
`define EXDM_OP_RRC_ACC 6'h1d
`endif

// *** src/exdm_mem.v ***
`timescale 1ns/10ps
`default_nettype none
module exdm_mem #(
  parameter AW = 10,
  parameter DW = 8
) (
  input wire aclk,
  input wire ce,
  input wire rd_en,
  input wire wr_en,
  input wire [AW-1:0] addr,
  input wire [DW-1:0] wr_data,
  output reg [DW-1:0] rd_data
);
  reg [DW-1:0] store [0:(1<<AW)-1];

  // read data always comes out of a register
  always @(posedge aclk) begin
    if (ce) begin
      if (wr_en) begin
        store[addr] <= wr_data;
      end
      if (rd_en) begin
        rd_data <= store[addr];
      end
    end
  end
endmodule // exdm_mem
`default_nettype wire

// *** src/exdm_adder.v ***
`timescale 1ns/10ps
`default_nettype none
module exdm_adder (
  input wire [7:0] a,
  input wire [7:0] b,
  input wire cin,
  output wire [7:0] sum,
  output wire carry,
  output wire half_carry,
  output wire overflow_flag,
  output wire signed_carry_flag
);
  wire [4:0] low;
  wire [3:0] mid;
  wire [1:0] top;

  // split at bit 3 and bit 6 to expose the inner carries
  assign low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  assign mid = {1'b0, a[6:4]} + {1'b0, b[6:4]} + {3'h0, low[4]};
  assign top = {1'b0, a[7]} + {1'b0, b[7]} + {1'b0, mid[3]};
  assign sum = {top[0], mid[2:0], low[3:0]};
  assign carry = top[1];
  assign half_carry = low[4];
  assign overflow_flag = top[1] ^ mid[3];
  // sign of the true nine-bit result
  assign signed_carry_flag = overflow_flag ^ top[0];
endmodule // exdm_adder
`default_nettype wire

// *** src/exdm_top.v ***
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "exdm_map.vh"
module exdm_top #(
  parameter MEM_AW = 10
) (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output wire busy
);
  localparam ST_IDLE = 3'b001;
  localparam ST_READ = 3'b010;
  localparam ST_EXEC = 3'b100;
  localparam IDX_CMD = 3'd0;
  localparam IDX_ADDR = 3'd1;
  localparam IDX_IMM = 3'd2;
  localparam IDX_ACC = 3'd3;
  localparam IDX_FLAG = 3'd4;
  localparam IDX_STAT = 3'd5;
  localparam IDX_NONE = 3'd7;

  reg [2:0] state;
  reg [5:0] op;
  reg [2:0] bit_idx;
  reg [MEM_AW-1:0] mem_addr;
  reg [7:0] imm;
  reg [7:0] acc;
  reg [4:0] flags;
  reg [7:0] last_result;
  reg bad_op;
  wire [7:0] mem_q;

  reg [7:0] next_result;
  reg [4:0] next_flags;
  reg [7:0] add_a;
  reg [7:0] add_b;
  reg add_cin;
  wire [7:0] add_sum;
  wire add_c;
  wire add_ac;
  wire add_ov;
  wire add_sc;
  wire lo_adj;
  wire hi_adj;
  wire [2:0] wr_idx;
  wire [2:0] rd_idx;
  wire wr_go;
  wire rd_go;
  wire exec_now;
  wire mem_we;

  //////////////////////////////////////////////////////////////////////
  // decode helpers

  function [2:0] reg_index;
    input [7:0] a;
    begin
      case (a)
        `EXDM_OFF_CMD: reg_index = IDX_CMD;
        `EXDM_OFF_ADDR: reg_index = IDX_ADDR;
        `EXDM_OFF_IMM: reg_index = IDX_IMM;
        `EXDM_OFF_ACC: reg_index = IDX_ACC;
        `EXDM_OFF_FLAG: reg_index = IDX_FLAG;
        `EXDM_OFF_STAT: reg_index = IDX_STAT;
        default: reg_index = IDX_NONE;
      endcase
    end
  endfunction

  // forms whose result lands in data memory
  function dest_mem;
    input [5:0] o;
    begin
      case (o)
        `EXDM_OP_XOR_MEM, `EXDM_OP_ADC_MEM, `EXDM_OP_ADD_MEM,
        `EXDM_OP_AND_MEM, `EXDM_OP_OR_MEM, `EXDM_OP_CLR_MEM,
        `EXDM_OP_CLR_BIT, `EXDM_OP_INV_MEM, `EXDM_OP_DAA,
        `EXDM_OP_DEC_MEM, `EXDM_OP_INC_MEM, `EXDM_OP_MOV_MEM,
        `EXDM_OP_RL_MEM, `EXDM_OP_RLC_MEM, `EXDM_OP_RR_MEM,
        `EXDM_OP_RRC_MEM: dest_mem = 1'b1;
        default: dest_mem = 1'b0;
      endcase
    end
  endfunction

  function known_op;
    input [5:0] o;
    begin
      known_op = (o <= `EXDM_OP_RRC_ACC);
    end
  endfunction

  function zero8;
    input [7:0] v;
    begin
      zero8 = ~|v;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // data memory and adder

  assign exec_now = ce & state[2];
  assign mem_we = exec_now & known_op(op) & dest_mem(op);

  exdm_mem #(
    .AW(MEM_AW),
    .DW(8)
  ) u_mem (
    .aclk(aclk),
    .ce(ce),
    .rd_en(state[1]),
    .wr_en(mem_we),
    .addr(mem_addr),
    .wr_data(next_result),
    .rd_data(mem_q)
  );

  exdm_adder u_add (
    .a(add_a),
    .b(add_b),
    .cin(add_cin),
    .sum(add_sum),
    .carry(add_c),
    .half_carry(add_ac),
    .overflow_flag(add_ov),
    .signed_carry_flag(add_sc)
  );

  // decimal adjust tests on the accumulator and flags
  assign lo_adj = (acc[3:0] > `EXDM_BCD_MAX) | flags[`EXDM_F_AC];
  assign hi_adj = (acc[7:4] > `EXDM_BCD_MAX) | flags[`EXDM_F_C];

  always @* begin
    add_a = mem_q;
    add_b = acc;
    add_cin = 1'b0;
    case (op)
      `EXDM_OP_ADC_ACC, `EXDM_OP_ADC_MEM: begin
        add_cin = flags[`EXDM_F_C];
      end
      `EXDM_OP_DAA: begin
        add_a = acc;
        add_b = {(hi_adj ? `EXDM_BCD_ADJ : 4'h0), (lo_adj ? `EXDM_BCD_ADJ : 4'h0)};
      end
      `EXDM_OP_DEC_MEM, `EXDM_OP_DEC_ACC: begin
        add_b = 8'hff;
      end
      `EXDM_OP_INC_MEM, `EXDM_OP_INC_ACC: begin
        add_b = 8'h01;
      end
      default: begin
        add_cin = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // operation results; flags not named keep their value

  always @* begin
    next_result = acc;
    next_flags = flags;
    case (op)
      `EXDM_OP_XOR_IMM: begin
        next_result = acc ^ imm;
        next_flags[`EXDM_F_Z] = zero8(acc ^ imm);
      end
      `EXDM_OP_XOR_ACC, `EXDM_OP_XOR_MEM: begin
        next_result = acc ^ mem_q;
        next_flags[`EXDM_F_Z] = zero8(acc ^ mem_q);
      end
      `EXDM_OP_ADC_ACC, `EXDM_OP_ADC_MEM, `EXDM_OP_ADD_ACC, `EXDM_OP_ADD_MEM: begin
        next_result = add_sum;
        next_flags[`EXDM_F_C] = add_c;
        next_flags[`EXDM_F_AC] = add_ac;
        next_flags[`EXDM_F_OV] = add_ov;
        next_flags[`EXDM_F_SC] = add_sc;
        next_flags[`EXDM_F_Z] = zero8(add_sum);
      end
      `EXDM_OP_AND_ACC, `EXDM_OP_AND_MEM: begin
        next_result = acc & mem_q;
        next_flags[`EXDM_F_Z] = zero8(acc & mem_q);
      end
      `EXDM_OP_OR_ACC, `EXDM_OP_OR_MEM: begin
        next_result = acc | mem_q;
        next_flags[`EXDM_F_Z] = zero8(acc | mem_q);
      end
      `EXDM_OP_CLR_MEM: begin
        next_result = 8'h00;
      end
      `EXDM_OP_CLR_BIT: begin
        next_result = mem_q & ~(8'h01 << bit_idx);
      end
      `EXDM_OP_INV_MEM, `EXDM_OP_INV_ACC: begin
        next_result = ~mem_q;
        next_flags[`EXDM_F_Z] = zero8(~mem_q);
      end
      `EXDM_OP_DAA: begin
        next_result = add_sum;
        // carry stays set or is raised by the high adjust
        next_flags[`EXDM_F_C] = flags[`EXDM_F_C] | add_c;
      end
      `EXDM_OP_DEC_MEM, `EXDM_OP_DEC_ACC, `EXDM_OP_INC_MEM, `EXDM_OP_INC_ACC: begin
        next_result = add_sum;
        next_flags[`EXDM_F_Z] = zero8(add_sum);
      end
      `EXDM_OP_MOV_ACC: begin
        next_result = mem_q;
      end
      `EXDM_OP_MOV_MEM: begin
        next_result = acc;
      end
      `EXDM_OP_RL_MEM, `EXDM_OP_RL_ACC: begin
        next_result = {mem_q[6:0], mem_q[7]};
      end
      `EXDM_OP_RLC_MEM, `EXDM_OP_RLC_ACC: begin
        next_result = {mem_q[6:0], flags[`EXDM_F_C]};
        next_flags[`EXDM_F_C] = mem_q[7];
      end
      `EXDM_OP_RR_MEM, `EXDM_OP_RR_ACC: begin
        next_result = {mem_q[0], mem_q[7:1]};
      end
      `EXDM_OP_RRC_MEM, `EXDM_OP_RRC_ACC: begin
        next_result = {flags[`EXDM_F_C], mem_q[7:1]};
        next_flags[`EXDM_F_C] = mem_q[0];
      end
      default: begin
        next_result = acc;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // axi4-lite handshakes; writes wait while an operation runs

  assign wr_idx = reg_index(s_axi_awaddr);
  assign rd_idx = reg_index(s_axi_araddr);
  assign wr_go = ce & state[0] & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign rd_go = ce & s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  assign busy = ~state[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EXDM_RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_idx == IDX_NONE) ? `EXDM_RESP_SLVERR : `EXDM_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `EXDM_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else if (ce) begin
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `EXDM_RESP_OKAY;
        case (rd_idx)
          IDX_CMD: s_axi_rdata <= {21'h000000, bit_idx, 2'b00, op};
          IDX_ADDR: s_axi_rdata <= {{(32-MEM_AW){1'b0}}, mem_addr};
          IDX_IMM: s_axi_rdata <= {24'h000000, imm};
          IDX_ACC: s_axi_rdata <= {24'h000000, acc};
          IDX_FLAG: s_axi_rdata <= {27'h0000000, flags};
          IDX_STAT: s_axi_rdata <= {16'h0000, last_result, 6'h00, bad_op, busy};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `EXDM_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register file and sequencer

  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      op <= 6'h00;
      bit_idx <= 3'h0;
      mem_addr <= {MEM_AW{1'b0}};
      imm <= `EXDM_RST_BYTE;
      acc <= `EXDM_RST_BYTE;
      flags <= `EXDM_RST_FLAG;
      last_result <= `EXDM_RST_BYTE;
      bad_op <= 1'b0;
    end else if (ce) begin
      case (state)
        ST_IDLE: begin
          if (wr_go) begin
            case (wr_idx)
              IDX_CMD: begin
                if (s_axi_wstrb[1]) begin
                  bit_idx <= s_axi_wdata[10:8];
                end
                // a low-byte write launches the operation
                if (s_axi_wstrb[0]) begin
                  op <= s_axi_wdata[5:0];
                  bad_op <= 1'b0;
                  state <= ST_READ;
                end
              end
              IDX_ADDR: begin
                if (s_axi_wstrb[0]) begin
                  mem_addr[7:0] <= s_axi_wdata[7:0];
                end
                if (s_axi_wstrb[1]) begin
                  mem_addr[MEM_AW-1:8] <= s_axi_wdata[MEM_AW-1:8];
                end
              end
              IDX_IMM: begin
                if (s_axi_wstrb[0]) begin
                  imm <= s_axi_wdata[7:0];
                end
              end
              IDX_ACC: begin
                if (s_axi_wstrb[0]) begin
                  acc <= s_axi_wdata[7:0];
                end
              end
              IDX_FLAG: begin
                if (s_axi_wstrb[0]) begin
                  flags <= s_axi_wdata[4:0];
                end
              end
              default: begin
                state <= ST_IDLE;
              end
            endcase
          end
        end
        ST_READ: begin
          state <= ST_EXEC;
        end
        ST_EXEC: begin
          state <= ST_IDLE;
          if (known_op(op)) begin
            flags <= next_flags;
            last_result <= next_result;
            if (!dest_mem(op)) begin
              acc <= next_result;
            end
          end else begin
            bad_op <= 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // exdm_top
`default_nettype wire

// *** sim/exdm_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "exdm_map.vh"
module exdm_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic busy
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] last_ar;
  wire logic aw_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire logic map_w = (s_axi_awaddr <= `EXDM_OFF_STAT) && (s_axi_awaddr[1:0] == 2'h0);
  wire logic map_r = (last_ar <= `EXDM_OFF_STAT) && (last_ar[1:0] == 2'h0);
  // address of the read now being answered
  always @(posedge aclk) begin
    if (!aresetn) begin
      last_ar <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      last_ar <= s_axi_araddr;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_ready_pair: assert property (s_axi_awready == s_axi_wready)
    else $error("write address and data ready differ");
  a_write_answer: assert property (aw_hs |=> s_axi_bvalid &&
    s_axi_bresp == ($past(map_w) ? `EXDM_RESP_OKAY : `EXDM_RESP_SLVERR))
    else $error("write response missing or wrong");
  a_op_two_busy: assert property (aw_hs && s_axi_awaddr == `EXDM_OFF_CMD &&
    s_axi_wstrb[0] && s_axi_wdata[5:0] <= 6'h1d |=> busy ##1 busy ##1 !busy)
    else $error("operation busy span wrong");
  a_no_take_busy: assert property (busy |-> !s_axi_awready)
    else $error("write taken while busy");
  a_ce_freeze: assert property (!ce |-> !s_axi_awready && !s_axi_arready)
    else $error("request taken with clock enable low");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer not held");
  a_acc_width: assert property (s_axi_rvalid && last_ar == `EXDM_OFF_ACC |->
    s_axi_rdata[31:8] == 24'h0)
    else $error("accumulator wider than a byte");
  a_flag_width: assert property (s_axi_rvalid && last_ar == `EXDM_OFF_FLAG |->
    s_axi_rdata[31:5] == 27'h0)
    else $error("flag word has stray bits");
  a_rd_unmapped: assert property (s_axi_rvalid && !map_r |->
    s_axi_rresp == `EXDM_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule // exdm_assertions
bind exdm_top exdm_assertions u_chk (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .busy);
`default_nettype wire

// *** sim/extended_data_memory_alu_ops_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "exdm_map.vh"
module extended_data_memory_alu_ops_tb;
  logic aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, d;
  logic [3:0] s_axi_wstrb;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, busy;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int miscompares, total_checks, i;
  exdm_top #(.MEM_AW(10)) uut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .busy);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input [31:0] seen, input [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic tmo;
    chk(32'h0, 32'h1);
    end_sim;
  endtask
  function automatic [31:0] resp_of(input [7:0] a);
    return (a <= `EXDM_OFF_STAT && a[1:0] == 2'h0) ? 32'h0 : {30'h0, `EXDM_RESP_SLVERR};
  endfunction
  task automatic wr(input [7:0] a, input [31:0] v);
    int n;
    logic ha, hw, hb;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    hb = 1'b0;
    for (n = 0; !hb; n++) begin
      if (n > 100) tmo;
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) s_axi_bready <= 1'b0;
    end
    chk({30'h0, r}, resp_of(a));
  endtask
  // rready stands from the request until the answer is taken
  task automatic rd(input [7:0] a, output [31:0] v);
    int n;
    logic ha, hr;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    hr = 1'b0;
    for (n = 0; !hr; n++) begin
      if (n > 100) tmo;
      @(negedge aclk);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid && s_axi_rready;
      v = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hr) s_axi_rready <= 1'b0;
    end
    chk({30'h0, r}, resp_of(a));
  endtask
  task automatic wait_idle;
    int n;
    for (n = 0; busy !== 1'b0; n++) begin
      if (n > 50) tmo;
      @(negedge aclk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // expected {memory destination, acc, memory, flags}; immediate holds the memory byte
  function automatic [21:0] model(input [5:0] op, input [2:0] bi, input [7:0] a,
                                  input [7:0] m, input [4:0] f);
    logic [8:0] s;
    logic [4:0] h, nf;
    logic [7:0] r, adj;
    logic dm, ov;
    nf = f;
    s = a + m + ((op == 6'h03 || op == 6'h04) ? f[0] : 1'b0);
    h = a[3:0] + m[3:0] + ((op == 6'h03 || op == 6'h04) ? f[0] : 1'b0);
    r = s[7:0];
    ov = (a[7] == m[7]) && (r[7] != a[7]);
    if (op >= 6'h03 && op <= 6'h06) nf = {ov ^ r[7], ov, r == 8'h00, h[4], s[8]};
    case (op)
      6'h00, 6'h01, 6'h02: r = a ^ m;
      6'h07, 6'h08: r = a & m;
      6'h09, 6'h0a: r = a | m;
      6'h0b: r = 8'h00;
      6'h0c: begin
        r = m;
        r[bi] = 1'b0;
      end
      6'h0d, 6'h0e: r = ~m;
      6'h0f: begin
        adj = {(a[7:4] > 4'h9 || f[0]) ? 4'h6 : 4'h0, (a[3:0] > 4'h9 || f[1]) ? 4'h6 : 4'h0};
        s = a + adj;
        r = s[7:0];
        nf[0] = f[0] | s[8];
      end
      6'h10, 6'h11: r = m - 8'h01;
      6'h12, 6'h13: r = m + 8'h01;
      6'h14: r = m;
      6'h15: r = a;
      6'h16, 6'h17: r = {m[6:0], m[7]};
      6'h18, 6'h19: begin
        r = {m[6:0], f[0]};
        nf[0] = m[7];
      end
      6'h1a, 6'h1b: r = {m[0], m[7:1]};
      6'h1c, 6'h1d: begin
        r = {f[0], m[7:1]};
        nf[0] = m[0];
      end
      default: ;
    endcase
    if (op <= 6'h02 || (op >= 6'h07 && op <= 6'h0a) || op == 6'h0d || op == 6'h0e ||
        (op >= 6'h10 && op <= 6'h13)) nf[2] = (r == 8'h00);
    dm = op < 6'h1e && (op == 6'h0b || op == 6'h0d || op == 6'h0f || op == 6'h15 ||
         (op != 6'h00 && op != 6'h0e && op != 6'h14 && !op[0]));
    return {dm, (dm || op > 6'h1d) ? a : r, dm ? r : m, nf};
  endfunction
  task automatic run(input [5:0] op, input [2:0] bi, input [9:0] ad, input [7:0] a,
                     input [7:0] m, input [4:0] f);
    logic [21:0] e;
    logic [31:0] v;
    e = model(op, bi, a, m, f);
    wr(`EXDM_OFF_ACC, {24'h0, m});
    wr(`EXDM_OFF_ADDR, {22'h0, ad});
    wr(`EXDM_OFF_IMM, {24'h0, m});
    wr(`EXDM_OFF_CMD, {26'h0, `EXDM_OP_MOV_MEM});
    wr(`EXDM_OFF_ACC, {24'h0, a});
    wr(`EXDM_OFF_FLAG, {27'h0, f});
    wr(`EXDM_OFF_CMD, {21'h0, bi, 2'h0, op});
    wait_idle;
    rd(`EXDM_OFF_ACC, v);
    chk(v, {24'h0, e[20:13]});
    rd(`EXDM_OFF_FLAG, v);
    chk(v, {27'h0, e[4:0]});
    rd(`EXDM_OFF_STAT, v);
    // an unknown opcode keeps the byte left by the move that loaded memory
    chk(v, {16'h0, (op > 6'h1d) ? m : (e[21] ? e[12:5] : e[20:13]), 6'h0, op > 6'h1d, 1'b0});
    wr(`EXDM_OFF_CMD, {26'h0, `EXDM_OP_MOV_ACC});
    wait_idle;
    rd(`EXDM_OFF_ACC, v);
    chk(v, {24'h0, e[12:5]});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_awprot = 3'h0;
    s_axi_arprot = 3'h0;
    miscompares = 0;
    total_checks = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`EXDM_OFF_ACC, d);
    chk(d, 32'h0);
    rd(`EXDM_OFF_FLAG, d);
    chk(d, 32'h0);
    @(posedge aclk);
    ce <= 1'b0;
    repeat (3) @(posedge aclk);
    ce <= 1'b1;
    $display("test reset done");
    for (i = 0; i < 30; i++) begin
      run(6'(i), 3'(i), 10'(i * 35), 8'(90 + i * 37), 8'(153 + i * 23), 5'(i ^ 21));
    end
    $display("test opcode sweep done");
    run(6'h05, 3'h0, 10'h3ff, 8'h80, 8'h80, 5'h00);
    run(6'h03, 3'h0, 10'h000, 8'hff, 8'h00, 5'h01);
    run(6'h0f, 3'h0, 10'h155, 8'hb5, 8'h00, 5'h02);
    run(6'h13, 3'h0, 10'h200, 8'h00, 8'hff, 5'h1b);
    run(6'h10, 3'h0, 10'h2aa, 8'h00, 8'h00, 5'h04);
    run(6'h0c, 3'h7, 10'h3ff, 8'h00, 8'hff, 5'h00);
    run(6'h1c, 3'h0, 10'h100, 8'h00, 8'h01, 5'h01);
    $display("test boundary done");
    wr(8'h18, 32'h1);
    rd(8'h18, d);
    chk(d, 32'h0);
    wr(`EXDM_OFF_STAT, 32'hffffffff);
    wr(`EXDM_OFF_CMD, 32'h3f);
    wait_idle;
    rd(`EXDM_OFF_STAT, d);
    chk(d & 32'h3, 32'h2);
    run(6'h1e, 3'h0, 10'h001, 8'h12, 8'h34, 5'h1f);
    $display("test decode done");
    // reset in mid-run brings accumulator and status back to zero
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`EXDM_OFF_ACC, d);
    chk(d, 32'h0);
    rd(`EXDM_OFF_STAT, d);
    chk(d, 32'h0);
    $display("test second reset done");
    end_sim;
  end
  initial begin
    repeat (100000) @(posedge aclk);
    tmo;
  end
endmodule // extended_data_memory_alu_ops_tb
`default_nettype wire
